// ### hdl/gimc_pkg.sv
/*
 * Shared constants and types for the gate input mode commutation pair:
 * input modes, half-bridge leg states, commutation table keys, widths.
 * Assumes both ends, the checks and the bench use these by scoped name.
 */
package gimc_pkg;

    localparam int NUM_PHASES = 3;
    localparam int PHASE_A = 0;
    localparam int PHASE_B = 1;
    localparam int PHASE_C = 2;

    // commutation code width and dead-time setting width (cycles of clock)
    localparam int CODE_W = 3;
    localparam int DEAD_W = 4;
    localparam int KEY_W = 4;
    localparam int SYNC_W = 6;

    localparam logic FREEWHEEL_ACTIVE = 1'h1;
    localparam logic FREEWHEEL_DIODE = 1'h0;

    typedef enum logic [1:0] {
        GIMC_MODE_SIX = 2'b00,
        GIMC_MODE_THREE = 2'b01,
        GIMC_MODE_SINGLE = 2'b10,
        GIMC_MODE_OFF = 2'b11
    } gimc_mode_t;

    // what one half-bridge does in single-PWM mode
    typedef enum logic [1:0] {
        GIMC_LEG_OFF = 2'b00,
        GIMC_LEG_LOW = 2'b01,
        GIMC_LEG_PWM = 2'b10
    } gimc_leg_t;

    // table key: {code bit0, code bit1, code bit2, dwell}
    localparam logic [KEY_W-1:0] KEY_AB = 4'h6;
    localparam logic [KEY_W-1:0] KEY_AB_CB = 4'h5;
    localparam logic [KEY_W-1:0] KEY_CB = 4'h4;
    localparam logic [KEY_W-1:0] KEY_CB_CA = 4'hD;
    localparam logic [KEY_W-1:0] KEY_CA = 4'hC;
    localparam logic [KEY_W-1:0] KEY_CA_BA = 4'h9;
    localparam logic [KEY_W-1:0] KEY_BA = 4'h8;
    localparam logic [KEY_W-1:0] KEY_BA_BC = 4'hB;
    localparam logic [KEY_W-1:0] KEY_BC = 4'hA;
    localparam logic [KEY_W-1:0] KEY_BC_AC = 4'h3;
    localparam logic [KEY_W-1:0] KEY_AC = 4'h2;
    localparam logic [KEY_W-1:0] KEY_AC_AB = 4'h7;
    localparam logic [KEY_W-1:0] KEY_ALIGN = 4'hE;
    localparam logic [KEY_W-1:0] KEY_STOP = 4'h0;

endpackage

// ### hdl/gimc_if.sv
/*
 * Pin bundle between the motor controller and the gate driver input logic:
 * six command pins, all driven by the controller.
 * Assumes the testbench instantiates it and joins both ends.
 */
`timescale 1ns/1ns
interface gimc_if;
    logic phase_a_high_command;
    logic phase_a_low_command;
    logic phase_b_high_command;
    logic phase_b_low_command;
    logic phase_c_high_command;
    logic phase_c_low_command;

    modport controller (
        output phase_a_high_command,
        output phase_a_low_command,
        output phase_b_high_command,
        output phase_b_low_command,
        output phase_c_high_command,
        output phase_c_low_command
    );

    modport driver (
        input phase_a_high_command,
        input phase_a_low_command,
        input phase_b_high_command,
        input phase_b_low_command,
        input phase_c_high_command,
        input phase_c_low_command
    );
endinterface

// ### hdl/gimc_driver.sv
/*
 * Gate driver input decoding: turns the six command pins into six gate
 * commands in six-input, three-input (with dead time) or single-PWM mode.
 * Assumes the pins come from another domain (two-flop synchronised here),
 * while mode, freewheel select and dead time are static settings on clock.
 */
`timescale 1ns/1ns
module gimc_driver (
    input wire logic clock,
    input wire logic rst_b,
    gimc_if.driver pins,
    input wire gimc_pkg::gimc_mode_t mode,
    input wire logic freewheel_select,
    input wire logic [gimc_pkg::DEAD_W-1:0] dead_time_setting,
    output logic [gimc_pkg::NUM_PHASES-1:0] high_gate_output,
    output logic [gimc_pkg::NUM_PHASES-1:0] low_gate_output
);

    logic [gimc_pkg::SYNC_W-1:0] sync_meta;
    logic [gimc_pkg::SYNC_W-1:0] sync_pins;
    logic [gimc_pkg::NUM_PHASES-1:0] high_cmd;
    logic [gimc_pkg::NUM_PHASES-1:0] low_cmd;
    logic [gimc_pkg::CODE_W-1:0] code;
    logic pwm;
    logic dwell;
    logic dwell_held;
    logic [gimc_pkg::KEY_W-1:0] key;
    logic [5:0] legs;
    logic [gimc_pkg::NUM_PHASES-1:0] dt_high;
    logic [gimc_pkg::NUM_PHASES-1:0] dt_low;
    logic [gimc_pkg::NUM_PHASES-1:0] next_high;
    logic [gimc_pkg::NUM_PHASES-1:0] next_low;

    // two flops on every pin before any decoding
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            sync_meta <= '0;
        end else begin
            sync_meta <= {pins.phase_c_low_command, pins.phase_c_high_command,
                          pins.phase_b_low_command, pins.phase_b_high_command,
                          pins.phase_a_low_command, pins.phase_a_high_command};
        end
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            sync_pins <= '0;
        end else begin
            sync_pins <= sync_meta;
        end
    end

    assign high_cmd = {sync_pins[4], sync_pins[2], sync_pins[0]};
    assign low_cmd = {sync_pins[5], sync_pins[3], sync_pins[1]};

    // single-PWM roles of the pins; phase C low is never read here
    assign pwm = high_cmd[gimc_pkg::PHASE_A];
    assign dwell = high_cmd[gimc_pkg::PHASE_C];

    // code and dwell registered together, so the table never sees a mixed key
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            code <= '0;
            dwell_held <= 1'h0;
        end else begin
            code <= {low_cmd[gimc_pkg::PHASE_B], high_cmd[gimc_pkg::PHASE_B],
                     low_cmd[gimc_pkg::PHASE_A]};
            dwell_held <= dwell;
        end
    end

    // dwell is not latched: the overlap row holds only while it is high
    assign key = {code[0], code[1], code[2], dwell_held};

    // legs packed as {C, B, A}
    function automatic logic [5:0] table_legs(input logic [gimc_pkg::KEY_W-1:0] k);
        logic [5:0] r;
        r = {gimc_pkg::GIMC_LEG_OFF, gimc_pkg::GIMC_LEG_OFF, gimc_pkg::GIMC_LEG_OFF};
        case (k)
            gimc_pkg::KEY_AB: begin
                r = {gimc_pkg::GIMC_LEG_OFF, gimc_pkg::GIMC_LEG_LOW, gimc_pkg::GIMC_LEG_PWM};
            end
            gimc_pkg::KEY_CB: begin
                r = {gimc_pkg::GIMC_LEG_PWM, gimc_pkg::GIMC_LEG_LOW, gimc_pkg::GIMC_LEG_OFF};
            end
            gimc_pkg::KEY_CA: begin
                r = {gimc_pkg::GIMC_LEG_PWM, gimc_pkg::GIMC_LEG_OFF, gimc_pkg::GIMC_LEG_LOW};
            end
            gimc_pkg::KEY_BA: begin
                r = {gimc_pkg::GIMC_LEG_OFF, gimc_pkg::GIMC_LEG_PWM, gimc_pkg::GIMC_LEG_LOW};
            end
            gimc_pkg::KEY_BC: begin
                r = {gimc_pkg::GIMC_LEG_LOW, gimc_pkg::GIMC_LEG_PWM, gimc_pkg::GIMC_LEG_OFF};
            end
            gimc_pkg::KEY_AC: begin
                r = {gimc_pkg::GIMC_LEG_LOW, gimc_pkg::GIMC_LEG_OFF, gimc_pkg::GIMC_LEG_PWM};
            end
            gimc_pkg::KEY_AB_CB: begin
                r = {gimc_pkg::GIMC_LEG_PWM, gimc_pkg::GIMC_LEG_LOW, gimc_pkg::GIMC_LEG_PWM};
            end
            gimc_pkg::KEY_CB_CA: begin
                r = {gimc_pkg::GIMC_LEG_PWM, gimc_pkg::GIMC_LEG_LOW, gimc_pkg::GIMC_LEG_LOW};
            end
            gimc_pkg::KEY_CA_BA: begin
                r = {gimc_pkg::GIMC_LEG_PWM, gimc_pkg::GIMC_LEG_PWM, gimc_pkg::GIMC_LEG_LOW};
            end
            gimc_pkg::KEY_BA_BC: begin
                r = {gimc_pkg::GIMC_LEG_LOW, gimc_pkg::GIMC_LEG_PWM, gimc_pkg::GIMC_LEG_LOW};
            end
            gimc_pkg::KEY_BC_AC: begin
                r = {gimc_pkg::GIMC_LEG_LOW, gimc_pkg::GIMC_LEG_PWM, gimc_pkg::GIMC_LEG_PWM};
            end
            gimc_pkg::KEY_AC_AB: begin
                r = {gimc_pkg::GIMC_LEG_LOW, gimc_pkg::GIMC_LEG_LOW, gimc_pkg::GIMC_LEG_PWM};
            end
            gimc_pkg::KEY_ALIGN: begin
                r = {gimc_pkg::GIMC_LEG_LOW, gimc_pkg::GIMC_LEG_LOW, gimc_pkg::GIMC_LEG_PWM};
            end
            gimc_pkg::KEY_STOP: begin
                r = {gimc_pkg::GIMC_LEG_OFF, gimc_pkg::GIMC_LEG_OFF, gimc_pkg::GIMC_LEG_OFF};
            end
            default: begin
                r = {gimc_pkg::GIMC_LEG_OFF, gimc_pkg::GIMC_LEG_OFF, gimc_pkg::GIMC_LEG_OFF};
            end
        endcase
        return r;
    endfunction

    assign legs = table_legs(key);

    // three-input dead time, one tracker per phase
    for (genvar p = 0; p < gimc_pkg::NUM_PHASES; p++) begin : g_dead
        logic applied;
        logic [gimc_pkg::DEAD_W-1:0] wait_count;

        // both gates off while a change waits out the dead time
        always_ff @(posedge clock or negedge rst_b) begin
            if (!rst_b) begin
                applied <= 1'h0;
                wait_count <= '0;
            end else if (high_cmd[p] != applied) begin
                if (wait_count >= dead_time_setting) begin
                    applied <= high_cmd[p];
                    wait_count <= '0;
                end else begin
                    wait_count <= wait_count + 1'h1;
                end
            end else begin
                wait_count <= '0;
            end
        end

        assign dt_high[p] = (high_cmd[p] == applied) && applied;
        assign dt_low[p] = (high_cmd[p] == applied) && !applied;
    end

    always_comb begin
        next_high = '0;
        next_low = '0;
        case (mode)
            gimc_pkg::GIMC_MODE_SIX: begin
                // equal commands mean the leg floats, never a shoot-through
                next_high = high_cmd & ~low_cmd;
                next_low = low_cmd & ~high_cmd;
            end
            gimc_pkg::GIMC_MODE_THREE: begin
                // low pins are not part of this path at all
                next_high = dt_high;
                next_low = dt_low;
            end
            gimc_pkg::GIMC_MODE_SINGLE: begin
                for (int p = 0; p < gimc_pkg::NUM_PHASES; p++) begin
                    case (gimc_pkg::gimc_leg_t'(legs[2*p +: 2]))
                        gimc_pkg::GIMC_LEG_PWM: begin
                            next_high[p] = pwm;
                            if (freewheel_select == gimc_pkg::FREEWHEEL_ACTIVE) begin
                                next_low[p] = !pwm;
                            end else begin
                                next_low[p] = 1'h0;
                            end
                        end
                        gimc_pkg::GIMC_LEG_LOW: begin
                            next_low[p] = 1'h1;
                        end
                        default: begin
                            next_high[p] = 1'h0;
                        end
                    endcase
                end
            end
            default: begin
                next_high = '0;
            end
        endcase
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            high_gate_output <= '0;
            low_gate_output <= '0;
        end else begin
            high_gate_output <= next_high;
            low_gate_output <= next_low;
        end
    end

endmodule

// ### hdl/gimc_controller.sv
/*
 * Controller end: drives the six command pins from user requests according
 * to the selected input mode.
 * Assumes user inputs are on clock; pins are registered before leaving.
 */
`timescale 1ns/1ns
module gimc_controller (
    input wire logic clock,
    input wire logic rst_b,
    gimc_if.controller pins,
    input wire gimc_pkg::gimc_mode_t mode,
    input wire logic [gimc_pkg::NUM_PHASES-1:0] user_high,
    input wire logic [gimc_pkg::NUM_PHASES-1:0] user_low,
    input wire logic pwm_level,
    input wire logic [gimc_pkg::CODE_W-1:0] commutation_code,
    input wire logic dwell_enable,
    input wire logic dwell_request
);

    logic [gimc_pkg::NUM_PHASES-1:0] next_high;
    logic [gimc_pkg::NUM_PHASES-1:0] next_low;
    logic [gimc_pkg::NUM_PHASES-1:0] high_pins;
    logic [gimc_pkg::NUM_PHASES-1:0] low_pins;

    always_comb begin
        next_high = '0;
        next_low = '0;
        case (mode)
            gimc_pkg::GIMC_MODE_SIX: begin
                next_high = user_high;
                next_low = user_low;
            end
            gimc_pkg::GIMC_MODE_THREE: begin
                // low pins parked, the driver ignores them anyway
                next_high = user_high;
            end
            gimc_pkg::GIMC_MODE_SINGLE: begin
                next_high[gimc_pkg::PHASE_A] = pwm_level;
                next_low[gimc_pkg::PHASE_A] = commutation_code[0];
                next_high[gimc_pkg::PHASE_B] = commutation_code[1];
                next_low[gimc_pkg::PHASE_B] = commutation_code[2];
                // without overlap use the dwell pin stays low
                next_high[gimc_pkg::PHASE_C] = dwell_enable && dwell_request;
            end
            default: begin
                next_high = '0;
            end
        endcase
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            high_pins <= '0;
            low_pins <= '0;
        end else begin
            high_pins <= next_high;
            low_pins <= next_low;
        end
    end

    assign pins.phase_a_high_command = high_pins[gimc_pkg::PHASE_A];
    assign pins.phase_b_high_command = high_pins[gimc_pkg::PHASE_B];
    assign pins.phase_c_high_command = high_pins[gimc_pkg::PHASE_C];
    assign pins.phase_a_low_command = low_pins[gimc_pkg::PHASE_A];
    assign pins.phase_b_low_command = low_pins[gimc_pkg::PHASE_B];
    assign pins.phase_c_low_command = low_pins[gimc_pkg::PHASE_C];

endmodule

// ### dv/gimc_sva.sv
/*
 * Concurrent checks on the pins between the two ends and on the gate outputs.
 * Assumes the testbench hands in the interface signals and the driver's mode and gates.
 */
`timescale 1ns/1ns
module gimc_sva (
    input wire logic clock,
    input wire logic rst_b,
    input wire gimc_pkg::gimc_mode_t mode,
    input wire logic phase_a_high_command,
    input wire logic phase_a_low_command,
    input wire logic phase_b_high_command,
    input wire logic phase_b_low_command,
    input wire logic phase_c_high_command,
    input wire logic phase_c_low_command,
    input wire logic [gimc_pkg::NUM_PHASES-1:0] high_gate_output,
    input wire logic [gimc_pkg::NUM_PHASES-1:0] low_gate_output
);
    wire six = mode == gimc_pkg::GIMC_MODE_SIX;
    wire three = mode == gimc_pkg::GIMC_MODE_THREE;
    wire single = mode == gimc_pkg::GIMC_MODE_SINGLE;
    wire [3:0] key = {phase_a_low_command, phase_b_high_command, phase_b_low_command,
        phase_c_high_command};
    logic [2:0] age;
    gimc_pkg::gimc_mode_t prev_mode;
    // pipeline is three to four deep, so checks wait until a mode has settled;
    // the first edge of a new mode still sees the old age, hence steady
    wire steady = mode == prev_mode;
    wire settled = steady && age >= 3'h5;

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            age <= 3'h0;
            prev_mode <= gimc_pkg::GIMC_MODE_SIX;
        end else begin
            prev_mode <= mode;
            age <= (mode != prev_mode) ? 3'h0 : ((age == 3'h7) ? age : age + 3'h1);
        end
    end

    default clocking @(posedge clock); endclocking
    default disable iff (!rst_b);

    a_six_high_a: assert property (six && settled |-> high_gate_output[0] ==
        ($past(phase_a_high_command, 3) & ~$past(phase_a_low_command, 3)))
        else $error("six-input high gate A wrong");
    a_six_low_b: assert property (six && settled |-> low_gate_output[1] ==
        ($past(phase_b_low_command, 3) & ~$past(phase_b_high_command, 3)))
        else $error("six-input low gate B wrong");
    a_three_low_comp: assert property (three && settled && low_gate_output[0]
        |-> !$past(phase_a_high_command, 3)) else $error("three-input low gate A wrong");
    a_three_dead_gap: assert property (three && settled && $rose(high_gate_output[0])
        |-> !$past(low_gate_output[0])) else $error("no dead time before high gate A");
    a_no_shoot_through: assert property ((high_gate_output & low_gate_output) == 3'h0)
        else $error("both gates of one phase on");
    a_three_low_quiet: assert property (three && steady && age >= 3'h2 |->
        !(phase_a_low_command | phase_b_low_command | phase_c_low_command))
        else $error("low pins active in three-input mode");
    a_single_pwm_follow: assert property (single && settled && high_gate_output[0]
        |-> $past(phase_a_high_command, 3)) else $error("high gate A not following PWM");
    a_single_c_low: assert property (single && steady && age >= 3'h2 |->
        !phase_c_low_command) else $error("phase C low pin active in single-PWM mode");
    a_single_stop: assert property (single && settled && $past(key, 4) == 4'h0 &&
        $past(key, 3) == 4'h0 |-> high_gate_output == 3'h0 && low_gate_output == 3'h0)
        else $error("stop state gates not all low");

    c_three_rise: cover property (three && $rose(high_gate_output[0]));
    c_single_dwell: cover property (single && phase_c_high_command && high_gate_output != 3'h0);
    c_six_high_c: cover property (six && high_gate_output[2]);
endmodule

// ### dv/test_gate_input_mode_commutation.sv
/*
 * Self-checking bench: controller end drives the driver end through the pin bundle.
 * Assumes both design ends and the package compile first; one clock of 20 MHz.
 */
`timescale 1ns/1ns
module test_gate_input_mode_commutation;
    logic clock = 1'h0;
    logic rst_b = 1'h0;
    gimc_pkg::gimc_mode_t mode = gimc_pkg::GIMC_MODE_SIX;
    logic freewheel_select = 1'h0;
    logic [3:0] dead_time_setting = 4'h3;
    logic [2:0] user_high = 3'h0;
    logic [2:0] user_low = 3'h0;
    logic pwm_level = 1'h0;
    logic [2:0] commutation_code = 3'h0;
    logic dwell_request = 1'h0;
    logic dwell_enable = 1'h1;
    logic [2:0] high_gate_output;
    logic [2:0] low_gate_output;
    logic [7:0] expected;
    int mismatches = 0;
    int comparisons = 0;
    int zero_cycles;
    wire [7:0] gates = {2'h0, low_gate_output, high_gate_output};

    gimc_if pins();
    gimc_controller i_gimc_controller (.clock(clock), .rst_b(rst_b), .pins(pins.controller),
        .mode(mode), .user_high(user_high), .user_low(user_low), .pwm_level(pwm_level),
        .commutation_code(commutation_code), .dwell_enable(dwell_enable),
        .dwell_request(dwell_request));
    gimc_driver i_gimc_driver (.clock(clock), .rst_b(rst_b), .pins(pins.driver), .mode(mode),
        .freewheel_select(freewheel_select), .dead_time_setting(dead_time_setting),
        .high_gate_output(high_gate_output), .low_gate_output(low_gate_output));
    gimc_sva i_gimc_sva (.clock(clock), .rst_b(rst_b), .mode(mode),
        .phase_a_high_command(pins.phase_a_high_command),
        .phase_a_low_command(pins.phase_a_low_command),
        .phase_b_high_command(pins.phase_b_high_command),
        .phase_b_low_command(pins.phase_b_low_command),
        .phase_c_high_command(pins.phase_c_high_command),
        .phase_c_low_command(pins.phase_c_low_command),
        .high_gate_output(high_gate_output), .low_gate_output(low_gate_output));

    initial begin
        forever #25 clock = ~clock;
    end

    task automatic step(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask

    task automatic compare(input logic [7:0] want, input logic [7:0] got);
        comparisons++;
        if (got !== want) begin
            mismatches++;
            $display("Error at %0t: expected %h, got %h", $time, want, got);
        end
    endtask

    task automatic results;
        $display("comparisons %0d, mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    // legs per phase in bits [1:0]=A: 0 off, 1 low on, 2 switched by PWM
    function automatic logic [5:0] expect_single(input logic [3:0] k, input logic p,
        input logic fw);
        logic [5:0] legs;
        logic [2:0] h;
        logic [2:0] l;
        case (k)
            4'h6: legs = 6'h06;
            4'h4: legs = 6'h24;
            4'hC: legs = 6'h21;
            4'h8: legs = 6'h09;
            4'hA: legs = 6'h18;
            4'h2: legs = 6'h12;
            4'h5: legs = 6'h26;
            4'hD: legs = 6'h25;
            4'h9: legs = 6'h29;
            4'hB: legs = 6'h19;
            4'h3: legs = 6'h1A;
            4'h7, 4'hE: legs = 6'h16;
            default: legs = 6'h00;
        endcase
        for (int i = 0; i < 3; i++) begin
            h[i] = (legs[2*i+:2] == 2'h2) & p;
            l[i] = (legs[2*i+:2] == 2'h1) |
                ((legs[2*i+:2] == 2'h2) & fw & ~p);
        end
        return {l, h};
    endfunction

    initial begin
        repeat (20) @(posedge clock);
        rst_b <= 1'h1;
        for (int i = 0; i < 64; i++) begin
            @(posedge clock);
            user_high <= i[2:0];
            user_low <= i[5:3];
            step(6);
            compare({2'h0, i[5:3] & ~i[2:0], i[2:0] & ~i[5:3]}, gates);
        end
        $display("six-input test done");
        @(posedge clock);
        mode <= gimc_pkg::GIMC_MODE_THREE;
        for (int i = 0; i < 8; i++) begin
            @(posedge clock);
            user_high <= i[2:0];
            user_low <= ~i[2:0];
            step(30);
            compare({2'h0, ~i[2:0], i[2:0]}, gates);
            compare(8'h0, {5'h0, pins.phase_a_low_command, pins.phase_b_low_command,
                pins.phase_c_low_command});
        end
        // smallest and largest dead time: count cycles with both A gates off
        for (int d = 0; d < 16; d += 15) begin
            @(posedge clock);
            dead_time_setting <= d[3:0];
            user_high <= 3'h0;
            step(30);
            @(posedge clock);
            user_high <= 3'h1;
            zero_cycles = 0;
            repeat (30) begin
                step(1);
                if (high_gate_output[0] === 1'h0 && low_gate_output[0] === 1'h0)
                    zero_cycles++;
            end
            compare(d[7:0] + 8'h1, zero_cycles[7:0]);
        end
        $display("three-input test done");
        @(posedge clock);
        mode <= gimc_pkg::GIMC_MODE_SINGLE;
        user_low <= 3'h7;
        for (int f = 0; f < 2; f++) begin
            for (int p = 0; p < 2; p++) begin
                for (int k = 0; k < 16; k++) begin
                    @(posedge clock);
                    freewheel_select <= f[0];
                    pwm_level <= p[0];
                    commutation_code <= {k[1], k[2], k[3]};
                    dwell_request <= k[0];
                    step(8);
                    expected = {2'h0, expect_single(k[3:0], p[0], f[0])};
                    compare(expected, gates);
                end
            end
        end
        // controller without overlap: a dwell request must not reach the pin
        @(posedge clock);
        freewheel_select <= 1'h1;
        pwm_level <= 1'h1;
        dwell_enable <= 1'h0;
        dwell_request <= 1'h1;
        commutation_code <= 3'h6;
        step(8);
        compare({2'h0, expect_single(4'h6, 1'h1, 1'h1)}, gates);
        $display("single-PWM test done");
        @(posedge clock);
        mode <= gimc_pkg::GIMC_MODE_OFF;
        step(8);
        compare(8'h0, gates);
        $display("off-mode test done");
        results();
    end
endmodule
